// ==== common/reset_clock_map.vh ====
// Register map, field positions and timing figures for reset and clock control
`ifndef RESET_CLOCK_MAP_VH
`define RESET_CLOCK_MAP_VH

// Register addresses
`define ADDR_MISC_PRESCALE    8'h94
`define ADDR_INT_FLAG         8'h95
`define ADDR_SW_COMMAND       8'h97
`define ADDR_CLOCK_CONTROL    8'hD8
`define ADDR_RC_TRIM          8'hF6
`define ADDR_AUX_TWO          8'hF7
`define ADDR_AUX_ONE          8'hF8

// Field positions
`define WD_PERIOD_HI          5
`define WD_PERIOD_LO          4
`define LV_FLAG_BIT           7
`define WD_ENABLE_HI          7
`define WD_ENABLE_LO          6
`define WD_CLEAR_BIT          7
`define SLOW_TYPE_BIT         7
`define FAST_TYPE_BIT         6
`define PERIPH_STOP_BIT       4
`define FAST_STOP_BIT         3
`define FAST_SELECT_BIT       2
`define DIVIDER_HI            1
`define DIVIDER_LO            0
`define TRIM_HI               6

// Values
`define SW_RESET_KEY          8'h56
`define LEVEL_WITH_DETECT     2'h3
`define DIVIDER_RESET         2'h3
`define DIV_BY_16             2'h0
`define DIV_BY_4              2'h1
`define DIV_BY_2              2'h2
`define ZERO_BYTE             8'h00

// Divider terminal counts (ratio minus one)
`define TERM_16               4'hF
`define TERM_4                4'h3
`define TERM_2                4'h1
`define TERM_1                4'h0

// Watchdog timing: shortest period, others are doublings of it
`define WD_BASE_MS            60
`define MCLK_KHZ              20000
`define WD_COUNT_WIDTH        24

`endif

// ==== src/clock_prescaler.v ====
// Source-tick divider that produces the system clock enable pulse
`timescale 1ns/1ps
`default_nettype none
`include "reset_clock_map.vh"

module clock_prescaler
(
  input  wire       mclk,
  input  wire       rst,
  input  wire       srcTick,
  input  wire [1:0] divSelect,
  output reg        sysTick
);

  reg  [3:0] divCount;
  reg  [3:0] termCount;

  // Ratio decode, changeable at run time
  always @*
  begin
    case (divSelect)
      `DIV_BY_16: termCount = `TERM_16;
      `DIV_BY_4:  termCount = `TERM_4;
      `DIV_BY_2:  termCount = `TERM_2;
      default:    termCount = `TERM_1;
    endcase
  end

  // Count source ticks; a shrunk ratio wraps at once rather than stall
  always @(posedge mclk)
  begin
    if (rst)
    begin
      divCount <= 4'h0;
      sysTick  <= 1'b0;
    end
    else
    begin
      sysTick <= 1'b0;
      if (srcTick)
      begin
        if (divCount >= termCount)
        begin
          divCount <= 4'h0;
          sysTick  <= 1'b1;
        end
        else
        begin
          divCount <= divCount + 4'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== src/reset_clock_control.v ====
// Reset sources, watchdog and system clock control behind the SFR port
//
// How it works
// - Two-bit level field selects reset threshold; 11 adds 2.4V detect.
// - Detect flag only meaningful at the 2.3V reset level.
// - Detect flag read-only, hardware set, held inactive in Stop mode.
// - Config bit gates the external reset pin.
// - Watchdog period field: 480, 240, 120 or 60 ms.
// - Writing 56h to the command register resets the device.
// - Watchdog enable: 0x off, 10 run modes, 11 always.
// - Clear bit restarts watchdog and self-clears next cycle.
// - System clock is source divided by 1, 2, 4 or 16.
// - Fast is crystal or RC halved; slow is crystal or RC.
// - After reset run slow mode from the internal slow RC.
// - Illegal clock control writes leave previous settings.
// - Slow type changes only while fast source selected.
// - Fast type changes only while slow source selected.
// - Seven-bit RC trim, monotonic, readable and writable.
// - Divider codes: 00 by 16, 01 by 4, 10 by 2, 11 by 1.
// - Fast select bit changes only while oscillator stop is zero.
// - Oscillator stop halts fast clock; changes only in slow mode.
// - Fast type 0 internal RC, 1 crystal with high gain.
`timescale 1ns/1ps
`default_nettype none
`include "reset_clock_map.vh"

module reset_clock_control
#(
  parameter WD_BASE_CYCLES = `WD_BASE_MS * `MCLK_KHZ
)
(
  input  wire       mclk,
  input  wire       rst,
  input  wire [7:0] sfrAddr,
  input  wire [7:0] sfrWrData,
  input  wire       sfrWr,
  input  wire       sfrRd,
  output reg  [7:0] sfrRdData,
  input  wire [1:0] lowVoltageLevelSelect,
  input  wire       pinResetEnable,
  input  wire       pinReset_n,
  input  wire       belowResetLevel,
  input  wire       belowDetectLevel,
  input  wire       idleMode,
  input  wire       stopMode,
  input  wire [6:0] factoryTrim,
  input  wire       fastCrystalTick,
  input  wire       fastRcTick,
  input  wire       slowCrystalTick,
  input  wire       slowRcTick,
  output wire [1:0] resetLevel,
  output wire       detectEnable,
  output reg        systemReset,
  output wire       slowSourceType,
  output wire       fastSourceType,
  output wire       fastCrystalHighGain,
  output wire       peripheralClockStop,
  output wire       fastOscillatorStop,
  output wire       fastSourceSelect,
  output wire [6:0] fastRcTrimValue,
  output wire       sysClkTick
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam [`WD_COUNT_WIDTH-1:0] WD_BASE = WD_BASE_CYCLES[`WD_COUNT_WIDTH-1:0];

  reg  [1:0]                 watchdogPeriodSelect;
  reg  [1:0]                 watchdogResetEnable;
  reg                        watchdogClear;
  reg  [`WD_COUNT_WIDTH-1:0] watchdogCounter;
  reg  [`WD_COUNT_WIDTH-1:0] watchdogLimit;
  reg                        lowVoltageDetectFlag;
  reg                        slowType;
  reg                        fastType;
  reg                        periphStop;
  reg                        fastStop;
  reg                        fastSelect;
  reg  [1:0]                 clockDivider;
  reg  [6:0]                 trimValue;
  reg                        fastRcHalf;
  reg                        next_slowType;
  reg                        next_fastType;
  reg                        next_fastStop;
  reg                        next_fastSelect;
  wire                       writeClock;
  wire                       swResetHit;
  wire                       pinResetHit;
  wire                       watchdogActive;
  wire                       watchdogExpire;
  wire                       resetCause;
  wire                       regReset;
  wire                       fastTick;
  wire                       slowTick;
  wire                       sourceTick;

  //////////////////////////////////////////////////////////////////////////////
  // Reset sources

  // Register reset covers the external reset and every internal source
  assign regReset = rst | systemReset;

  assign swResetHit = sfrWr & (sfrAddr == `ADDR_SW_COMMAND) &
                      (sfrWrData == `SW_RESET_KEY);

  assign pinResetHit = pinResetEnable & ~pinReset_n;

  assign resetCause = belowResetLevel | pinResetHit | swResetHit | watchdogExpire;

  // Registered so a self-caused reset does not form a combinational loop
  always @(posedge mclk)
  begin
    if (rst)
    begin
      systemReset <= 1'b0;
    end
    else
    begin
      systemReset <= resetCause;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Low voltage level and detect flag

  assign resetLevel   = lowVoltageLevelSelect;
  assign detectEnable = (lowVoltageLevelSelect == `LEVEL_WITH_DETECT);

  // Flag follows the comparator, only where it is valid
  always @(posedge mclk)
  begin
    if (regReset)
    begin
      lowVoltageDetectFlag <= 1'b0;
    end
    else
    begin
      lowVoltageDetectFlag <= belowDetectLevel & detectEnable & ~stopMode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog

  // period doubles per code step below 11
  always @*
  begin
    watchdogLimit = WD_BASE << (~watchdogPeriodSelect);
  end

  assign watchdogActive = watchdogResetEnable[1] &
                          (watchdogResetEnable[0] | ~(idleMode | stopMode));

  assign watchdogExpire = watchdogActive & (watchdogCounter >= watchdogLimit - 1'b1);

  // Counter also runs and holds at one below its limit when reset is disabled, so enabling it without a clear expires at once
  always @(posedge mclk)
  begin
    if (regReset)
    begin
      watchdogCounter <= {`WD_COUNT_WIDTH{1'b0}};
    end
    else if (watchdogClear)
    begin
      watchdogCounter <= {`WD_COUNT_WIDTH{1'b0}};
    end
    else if (watchdogCounter < watchdogLimit - 1'b1)
    begin
      watchdogCounter <= watchdogCounter + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock control write filter

  assign writeClock = sfrWr & (sfrAddr == `ADDR_CLOCK_CONTROL);

  // Gated fields judged against the settings in force before the write, the stop and select clash against the new values
  always @*
  begin
    next_slowType   = slowType;
    next_fastType   = fastType;
    next_fastStop   = fastStop;
    next_fastSelect = fastSelect;
    if (writeClock)
    begin
      // slow type only in fast mode
      if (fastSelect)
      begin
        next_slowType = sfrWrData[`SLOW_TYPE_BIT];
      end
      // fast type only in slow mode
      if (!fastSelect)
      begin
        next_fastType = sfrWrData[`FAST_TYPE_BIT];
      end
      // stop changes only in slow mode
      if (!fastSelect)
      begin
        next_fastStop = sfrWrData[`FAST_STOP_BIT];
      end
      // select changes only with stop clear
      if (!fastStop)
      begin
        next_fastSelect = sfrWrData[`FAST_SELECT_BIT];
      end
      // never let stop and select both land high
      if (next_fastStop && next_fastSelect)
      begin
        next_fastStop = fastStop;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes

  // reset to slow mode on internal RC
  always @(posedge mclk)
  begin
    if (regReset)
    begin
      slowType     <= 1'b0;
      fastType     <= 1'b0;
      periphStop   <= 1'b0;
      fastStop     <= 1'b0;
      fastSelect   <= 1'b0;
      clockDivider <= `DIVIDER_RESET;
    end
    else
    begin
      slowType   <= next_slowType;
      fastType   <= next_fastType;
      fastStop   <= next_fastStop;
      fastSelect <= next_fastSelect;
      if (writeClock)
      begin
        periphStop   <= sfrWrData[`PERIPH_STOP_BIT];
        clockDivider <= sfrWrData[`DIVIDER_HI:`DIVIDER_LO];
      end
    end
  end

  // Watchdog fields, clear strobe and trim
  always @(posedge mclk)
  begin
    if (regReset)
    begin
      watchdogPeriodSelect <= 2'h0;
      watchdogResetEnable  <= 2'h0;
      watchdogClear        <= 1'b0;
      trimValue            <= factoryTrim;
    end
    else
    begin
      if (sfrWr && (sfrAddr == `ADDR_MISC_PRESCALE))
      begin
        watchdogPeriodSelect <= sfrWrData[`WD_PERIOD_HI:`WD_PERIOD_LO];
      end
      if (sfrWr && (sfrAddr == `ADDR_AUX_TWO))
      begin
        watchdogResetEnable <= sfrWrData[`WD_ENABLE_HI:`WD_ENABLE_LO];
      end
      watchdogClear <= sfrWr & (sfrAddr == `ADDR_AUX_ONE) &
                       sfrWrData[`WD_CLEAR_BIT];
      // trim writable, loaded from factory at reset
      if (sfrWr && (sfrAddr == `ADDR_RC_TRIM))
      begin
        trimValue <= sfrWrData[`TRIM_HI:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Unused bits and write-only or unmapped addresses read zero
  always @(posedge mclk)
  begin
    if (regReset)
    begin
      sfrRdData <= `ZERO_BYTE;
    end
    else if (sfrRd)
    begin
      case (sfrAddr)
        `ADDR_MISC_PRESCALE:
          sfrRdData <= {2'h0, watchdogPeriodSelect, 4'h0};
        `ADDR_INT_FLAG:
          sfrRdData <= {lowVoltageDetectFlag, 7'h00};
        `ADDR_CLOCK_CONTROL:
          sfrRdData <= {slowType, fastType, 1'b0, periphStop,
                        fastStop, fastSelect, clockDivider};
        `ADDR_RC_TRIM:
          sfrRdData <= {1'b0, trimValue};
        `ADDR_AUX_TWO:
          sfrRdData <= {watchdogResetEnable, 6'h00};
        `ADDR_AUX_ONE:
          sfrRdData <= {watchdogClear, 7'h00};
        default:
          sfrRdData <= `ZERO_BYTE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock source selection

  always @(posedge mclk)
  begin
    if (regReset)
    begin
      fastRcHalf <= 1'b0;
    end
    else if (fastRcTick)
    begin
      fastRcHalf <= ~fastRcHalf;
    end
  end

  // fast type picks RC or crystal
  assign fastTick = fastStop ? 1'b0 :
                    (fastType ? fastCrystalTick : (fastRcTick & fastRcHalf));
  // slow type picks RC or crystal
  assign slowTick = slowType ? slowCrystalTick : slowRcTick;

  assign sourceTick = fastSelect ? fastTick : slowTick;

  // divider encoding lives in the prescaler
  clock_prescaler u_prescaler
  (
    .mclk      (mclk),
    .rst       (regReset),
    .srcTick   (sourceTick),
    .divSelect (clockDivider),
    .sysTick   (sysClkTick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator controls

  assign slowSourceType      = slowType;
  assign fastSourceType      = fastType;
  assign fastCrystalHighGain = fastType;
  assign peripheralClockStop = periphStop;
  assign fastOscillatorStop  = fastStop;
  assign fastSourceSelect    = fastSelect;
  assign fastRcTrimValue     = trimValue;

endmodule
`default_nettype wire

// ==== testbench/reset_clock_control_assertions.sv ====
// Port checker for reset sources and system clock control
`timescale 1ns/1ps
`default_nettype none
module reset_clock_control_checker
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrWr,
  input wire logic       sfrRd,
  input wire logic [7:0] sfrRdData,
  input wire logic [1:0] lowVoltageLevelSelect,
  input wire logic       pinResetEnable,
  input wire logic       pinReset_n,
  input wire logic       belowResetLevel,
  input wire logic       stopMode,
  input wire logic [1:0] resetLevel,
  input wire logic       detectEnable,
  input wire logic       systemReset,
  input wire logic       slowSourceType,
  input wire logic       fastSourceType,
  input wire logic       fastOscillatorStop,
  input wire logic       fastSourceSelect,
  input wire logic [6:0] fastRcTrimValue
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Clock control write that no reset overrides
  wire clkWr = sfrWr && sfrAddr == 8'hD8 && !systemReset;
  level_follow_a:
  assert property (resetLevel == lowVoltageLevelSelect
    && detectEnable == (lowVoltageLevelSelect == 2'b11)) else $error("level outputs wrong");
  detect_unused_a:
  assert property (sfrRd && sfrAddr == 8'h95 && $past(lowVoltageLevelSelect) != 2'b11
    |=> !sfrRdData[7]) else $error("detect flag set at wrong level");
  detect_stop_a:
  assert property (sfrRd && sfrAddr == 8'h95 && stopMode && $past(stopMode)
    |=> !sfrRdData[7]) else $error("detect flag set in stop");
  pin_reset_a:
  assert property (pinResetEnable && !pinReset_n |=> systemReset) else $error("pin reset lost");
  sw_reset_a:
  assert property (sfrWr && sfrAddr == 8'h97 && sfrWrData == 8'h56 |=> systemReset)
    else $error("command reset lost");
  low_reset_a:
  assert property (belowResetLevel |=> systemReset) else $error("low voltage reset lost");
  slow_default_a:
  assert property (systemReset |=> !fastSourceSelect && !slowSourceType
    && !fastOscillatorStop && !fastSourceType) else $error("not slow rc after reset");
  slow_type_gate_a:
  assert property (clkWr && !fastSourceSelect |=> $stable(slowSourceType))
    else $error("slow type changed in slow mode");
  fast_type_gate_a:
  assert property (clkWr && fastSourceSelect |=> $stable(fastSourceType)
    && $stable(fastOscillatorStop)) else $error("fast type or stop changed in fast mode");
  select_gate_a:
  assert property (clkWr && fastOscillatorStop |=> $stable(fastSourceSelect))
    else $error("select changed while stopped");
  trim_write_a:
  assert property (sfrWr && sfrAddr == 8'hF6 && !systemReset
    |=> fastRcTrimValue == $past(sfrWrData[6:0])) else $error("trim not written");
endmodule
bind reset_clock_control reset_clock_control_checker i_reset_clock_control_checker
(.mclk, .rst, .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrRdData, .lowVoltageLevelSelect,
 .pinResetEnable, .pinReset_n, .belowResetLevel, .stopMode, .resetLevel, .detectEnable,
 .systemReset, .slowSourceType, .fastSourceType, .fastOscillatorStop, .fastSourceSelect,
 .fastRcTrimValue);
`default_nettype wire

// ==== testbench/tb_reset_clock_control.sv ====
// Self-checking bench for reset sources and system clock control
`timescale 1ns/1ps
`default_nettype none
module tb_reset_clock_control;
  logic       mclk = 0, rst = 1, sfrWr = 0, sfrRd = 0, pinResetEnable = 0, pinReset_n = 1;
  logic       belowResetLevel = 0, belowDetectLevel = 0, idleMode = 0, stopMode = 0;
  logic       fastCrystalTick = 1, fastRcTick = 1, slowCrystalTick = 1, slowRcTick = 1;
  logic [7:0] sfrAddr = 0, sfrWrData = 0, sfrRdData, v;
  logic [1:0] lowVoltageLevelSelect = 0, resetLevel;
  logic [6:0] factoryTrim, fastRcTrimValue;
  logic       detectEnable, systemReset, slowSourceType, fastSourceType, fastCrystalHighGain;
  logic       peripheralClockStop, fastOscillatorStop, fastSourceSelect, sysClkTick;
  logic [31:0] seed = 32'hdc5a_3dd3;
  int         fail_count = 0, checks_done = 0, resets = 0, i, n, r0;
  // no pattern writes stop and select both high
  logic [7:0] tw [7] = '{8'h47, 8'h87, 8'h8B, 8'h83, 8'h43, 8'hCB, 8'hC7};
  logic [7:0] te [7] = '{8'h07, 8'h87, 8'h83, 8'h83, 8'hC3, 8'hCB, 8'hC3};
  // Short watchdog base keeps the run brief
  reset_clock_control #(.WD_BASE_CYCLES(16)) i_reset_clock_control (.*);
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) if (systemReset) resets++;
  // Slow crystal ticks every other cycle, so it differs from the slow RC
  always @(negedge mclk) slowCrystalTick <= ~slowCrystalTick;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    sfrWr = 1;
    sfrAddr = a;
    sfrWrData = d;
    @(negedge mclk);
    sfrWr = 0;
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] e, string nm);
    @(negedge mclk);
    sfrRd = 1;
    sfrAddr = a;
    @(negedge mclk);
    sfrRd = 0;
    chk(nm, e, sfrRdData);
  endtask
  // Settle after a divider change, then count ticks in a window of 64
  task automatic ticks(int e);
    int c;
    c = 0;
    repeat (32) @(negedge mclk);
    repeat (64)
    begin
      @(negedge mclk);
      c += sysClkTick;
    end
    chk("ticks", e[7:0], c[7:0]);
  endtask
  task automatic wdt(output int w);
    w = 0;
    while (!systemReset && w < 300)
    begin
      @(negedge mclk);
      w++;
    end
    if (w == 300)
    begin
      fail_count++;
      tally_and_finish;
    end
    @(negedge mclk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    factoryTrim = nxt() & 8'h7F;
    repeat (5) @(negedge mclk);
    rst = 0;
    rdc(8'hD8, 8'h03, "ctlReset");
    rdc(8'hF6, {1'b0, factoryTrim}, "trimReset");
    chk("periphReset", 0, peripheralClockStop);
    wr(8'hD8, 8'h13);
    chk("periphStop", 1, peripheralClockStop);
    // Divider codes on the slow source, then fast rc halved
    for (i = 0; i < 4; i++)
    begin
      wr(8'hD8, i[7:0]);
      ticks(i == 0 ? 4 : 64 >> (3 - i));
    end
    wr(8'hD8, 8'h07);
    ticks(32);
    // Gated fields: refused writes keep the old setting
    for (i = 0; i < 7; i++)
    begin
      wr(8'hD8, tw[i]);
      rdc(8'hD8, te[i], "ctlGate");
    end
    // Slow crystal now selected at divide by one
    ticks(32);
    // Crystal must settle before it is selected
    repeat (40000) @(negedge mclk);
    wr(8'hD8, 8'hC7);
    chk("gain", 1, fastCrystalHighGain);
    ticks(64);
    $display("clock tests done");
    for (i = 0; i < 6; i++)
    begin
      v = i == 0 ? 8'h00 : i == 1 ? 8'h7F : nxt();
      wr(8'hF6, v);
      rdc(8'hF6, {1'b0, v[6:0]}, "trim");
    end
    // Detect flag against level and stop mode
    belowDetectLevel = 1;
    for (i = 0; i < 8; i++)
    begin
      lowVoltageLevelSelect = i[1:0];
      stopMode = i[2];
      rdc(8'h95, {i == 3, 7'h00}, "detect");
    end
    stopMode = 0;
    belowDetectLevel = 0;
    $display("trim and detect tests done");
    // Command register: only the key resets
    r0 = resets;
    for (i = 0; i < 6; i++)
    begin
      v = nxt();
      wr(8'h97, v == 8'h56 ? 8'h57 : v);
    end
    rdc(8'h97, 8'h00, "cmdRead");
    chk("cmdIgnored", r0[7:0], resets[7:0]);
    wr(8'h97, 8'h56);
    wdt(n);
    rdc(8'hD8, 8'h03, "ctlAfterCmd");
    // Pin reset gated by the enable, then low voltage
    r0 = resets;
    pinReset_n = 0;
    repeat (4) @(negedge mclk);
    chk("pinIgnored", r0[7:0], resets[7:0]);
    pinResetEnable = 1;
    wdt(n);
    pinReset_n = 1;
    pinResetEnable = 0;
    belowResetLevel = 1;
    wdt(n);
    belowResetLevel = 0;
    chk("pinLowCount", r0[7:0] + 2, resets[7:0]);
    $display("reset source tests done");
    // Watchdog periods in run mode
    for (i = 0; i < 4; i++)
    begin
      wr(8'h94, {2'b00, i[1:0], 4'h0});
      wr(8'hF8, 8'h80);
      wr(8'hF7, 8'h80);
      wdt(n);
      chk("wdtPeriod", 1, n >= (16 << (3 - i)) - 4 && n <= (16 << (3 - i)) + 2);
      rdc(8'hF7, 8'h00, "wdtEnReset");
    end
    // Clearing holds off expiry; run-only enable sleeps in idle
    r0 = resets;
    wr(8'h94, 8'h30);
    wr(8'hF8, 8'h80);
    rdc(8'hF8, 8'h00, "clearSelf");
    wr(8'hF7, 8'h80);
    repeat (8)
    begin
      wr(8'hF8, 8'h80);
      repeat (6) @(negedge mclk);
    end
    chk("wdtCleared", r0[7:0], resets[7:0]);
    idleMode = 1;
    repeat (60) @(negedge mclk);
    chk("wdtIdleOff", r0[7:0], resets[7:0]);
    wr(8'hF7, 8'hC0);
    wdt(n);
    chk("wdtIdleOn", 1, n <= 20);
    idleMode = 0;
    $display("watchdog tests done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
